/* File: core/wil_top.sv */
// wake pin logic with AXI4-Lite register access and interrupt pulse
// assumes power_mode and sense_strobe come from core_clk logic
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module wil_top #(
    parameter int INT_PULSE_CYC = wil_pkg::INT_PULSE_CYC,
    parameter int INT_GAP_CYC   = wil_pkg::INT_GAP_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        wake_pin,
    input  wire logic [1:0]  power_mode,
    input  wire logic        sense_strobe,
    output logic             pull_up_en,
    output logic             pull_down_en,
    output logic             mod_override,
    output logic             pwm_select,
    output logic             wake_request,
    output logic             restart_request,
    output logic             int_n,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic                  sync_level;
    logic                  filt_level;
    logic                  filt_prev_q;
    logic                  stored_q;
    logic                  edge_seen;
    logic                  en;
    logic                  mode_active;
    logic                  int_trig_q;
    logic [wil_pkg::CTRL_W-1:0] ctrl_q;
    logic                  pin_wake_flag_q;
    logic                  level_stat_q;
    logic [1:0]            irq_stat_q;
    logic [1:0]            irq_mask_q;
    logic [7:0]            awaddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  wr_go;
    logic                  wr_low;
    logic [1:0]            bias;

    wil_filter u_filter (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .wake_pin   (wake_pin),
        .sync_level (sync_level),
        .filt_level (filt_level)
    );

    wil_int_pulse #(
        .PULSE_CYC (INT_PULSE_CYC),
        .GAP_CYC   (INT_GAP_CYC)
    ) u_int_pulse (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .trigger  (int_trig_q),
        .int_n    (int_n)
    );

    assign en          = ctrl_q[wil_pkg::CTRL_EN_BIT];
    assign bias        = ctrl_q[wil_pkg::CTRL_BIAS_HI:wil_pkg::CTRL_BIAS_LO];
    assign mode_active = (power_mode == wil_pkg::MODE_NORMAL) || (power_mode == wil_pkg::MODE_STOP);

    // static: any accepted level change; cyclic: sample against stored
    always_comb begin
        if (ctrl_q[wil_pkg::CTRL_CYCLIC_BIT]) begin
            edge_seen = sense_strobe && (filt_level != stored_q);
        end else begin
            edge_seen = (filt_level != filt_prev_q);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_prev_q <= 1'b0;
            stored_q    <= 1'b0;
        end else begin
            filt_prev_q <= filt_level;
            if (sense_strobe) begin
                stored_q <= filt_level;
            end
        end
    end

    // mode outputs are requests only; mode changes are decided elsewhere
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_request    <= 1'b0;
            restart_request <= 1'b0;
            int_trig_q      <= 1'b0;
        end else begin
            restart_request <= edge_seen && (power_mode == wil_pkg::MODE_FAIL_SAFE);
            wake_request    <= edge_seen && en && (power_mode == wil_pkg::MODE_SLEEP);
            int_trig_q      <= edge_seen && en && mode_active;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_wake_flag_q <= 1'b0;
        end else begin
            pin_wake_flag_q <= (pin_wake_flag_q && !(wr_low && awaddr_q == wil_pkg::WAKE_STAT1_OFS && wdata_q[0]))
                               || wake_request || restart_request || int_trig_q;
        end
    end

    // level status stays out of the interrupt path
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            level_stat_q <= 1'b0;
        end else begin
            level_stat_q <= mode_active && sync_level;
        end
    end

    // bit0 pin interrupt event, bit1 wake or restart request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_q <= wil_pkg::IRQ_RST;
            irq     <= 1'b0;
        end else begin
            irq_stat_q[0] <= (irq_stat_q[0] && !(wr_low && awaddr_q == wil_pkg::IRQ_STAT_OFS && wdata_q[0]))
                             || int_trig_q;
            irq_stat_q[1] <= (irq_stat_q[1] && !(wr_low && awaddr_q == wil_pkg::IRQ_STAT_OFS && wdata_q[1]))
                             || wake_request || restart_request;
            irq           <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_up_en   <= 1'b0;
            pull_down_en <= 1'b0;
        end else begin
            case (bias)
                wil_pkg::BIAS_NONE: begin
                    pull_up_en   <= 1'b0;
                    pull_down_en <= 1'b0;
                end
                wil_pkg::BIAS_DOWN: begin
                    pull_up_en   <= 1'b0;
                    pull_down_en <= 1'b1;
                end
                wil_pkg::BIAS_UP: begin
                    pull_up_en   <= 1'b1;
                    pull_down_en <= 1'b0;
                end
                default: begin
                    pull_up_en   <= filt_level;
                    pull_down_en <= !filt_level;
                end
            endcase
        end
    end

    // unfiltered on purpose: the controller drives a clean level
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mod_override <= 1'b0;
            pwm_select   <= 1'b0;
        end else begin
            mod_override <= ctrl_q[wil_pkg::CTRL_MOD_BIT] && (power_mode == wil_pkg::MODE_STOP);
            pwm_select   <= ctrl_q[wil_pkg::CTRL_MOD_BIT] && (power_mode == wil_pkg::MODE_STOP) && sync_level;
        end
    end

    // address and data taken in either order, committed once both held
    assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_low = wr_go && wstrb_q[0];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= wil_pkg::RESP_OKAY;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    wil_pkg::CTRL_OFS, wil_pkg::WAKE_STAT1_OFS, wil_pkg::LEVEL_STAT_OFS,
                    wil_pkg::IRQ_STAT_OFS, wil_pkg::IRQ_MASK_OFS: s_axi_bresp <= wil_pkg::RESP_OKAY;
                    default: s_axi_bresp <= wil_pkg::RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q     <= wil_pkg::CTRL_RST;
            irq_mask_q <= wil_pkg::MASK_RST;
        end else if (wr_low) begin
            if (awaddr_q == wil_pkg::CTRL_OFS) begin
                ctrl_q <= wdata_q[wil_pkg::CTRL_W-1:0];
            end
            if (awaddr_q == wil_pkg::IRQ_MASK_OFS) begin
                irq_mask_q <= wdata_q[1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= wil_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= wil_pkg::RESP_OKAY;
            case (s_axi_araddr)
                wil_pkg::CTRL_OFS:       s_axi_rdata <= {27'h0, ctrl_q};
                wil_pkg::WAKE_STAT1_OFS: s_axi_rdata <= {31'h0, pin_wake_flag_q};
                wil_pkg::LEVEL_STAT_OFS: s_axi_rdata <= {31'h0, level_stat_q};
                wil_pkg::IRQ_STAT_OFS:   s_axi_rdata <= {30'h0, irq_stat_q};
                wil_pkg::IRQ_MASK_OFS:   s_axi_rdata <= {30'h0, irq_mask_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= wil_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    a_failsafe_restart: assert property (@(posedge core_clk) disable iff (!rst_b)
        (edge_seen && power_mode == wil_pkg::MODE_FAIL_SAFE) |=> restart_request)
        else $error("fail-safe edge gave no restart request");
    a_sleep_wake: assert property (@(posedge core_clk) disable iff (!rst_b)
        (edge_seen && en && power_mode == wil_pkg::MODE_SLEEP) |=> wake_request)
        else $error("sleep edge gave no wake request");
    a_disabled_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!en) |=> (!wake_request && !int_trig_q))
        else $error("disabled pin produced wake or interrupt");
    a_int_trigger: assert property (@(posedge core_clk) disable iff (!rst_b)
        (edge_seen && en && mode_active) |=> int_trig_q ##1 pin_wake_flag_q)
        else $error("active mode edge gave no interrupt and flag");
    a_cyclic_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ctrl_q[wil_pkg::CTRL_CYCLIC_BIT] && !sense_strobe) |-> !edge_seen)
        else $error("cyclic sensing saw edge outside active period");
    a_static_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!ctrl_q[wil_pkg::CTRL_CYCLIC_BIT] && $changed(filt_level) && $past(rst_b)) |-> edge_seen)
        else $error("static sensing missed a filtered edge");
    a_bias_auto: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bias == wil_pkg::BIAS_AUTO) |=> (pull_up_en == $past(filt_level) && pull_down_en != pull_up_en))
        else $error("automatic bias does not follow level");
    a_bias_fixed: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bias == wil_pkg::BIAS_NONE) |=> (!pull_up_en && !pull_down_en))
        else $error("bias current on with no source selected");
    a_mod_level: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ctrl_q[wil_pkg::CTRL_MOD_BIT] && power_mode == wil_pkg::MODE_STOP) |=> (pwm_select == $past(sync_level)))
        else $error("modulation select does not track pin");
    a_flag_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pin_wake_flag_q && !wr_go) |=> pin_wake_flag_q)
        else $error("wake flag cleared without software write");

    c_restart: cover property (@(posedge core_clk) disable iff (!rst_b) restart_request);
    c_wake: cover property (@(posedge core_clk) disable iff (!rst_b) wake_request);
    c_int_pulse: cover property (@(posedge core_clk) disable iff (!rst_b) $fell(int_n));
    c_pwm: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(pwm_select));
endmodule

/* File: core/wil_pkg.sv */
// constants and types of the wake input logic
// assumes one 100 MHz core clock and an AXI4-Lite master outside
// Functional notes
// - both pin edges count as wake events
// - normal or stop mode edge raises interrupt
// - sleep mode enabled edge wakes device
// - fail-safe mode edge always requests restart
// - option: pin level picks PFM or PWM; logic does so in stop mode only
// - modulation select bypasses the wake filter
// - level must persist filter time, else rejected
// - static or cyclic sensing selectable by software
// - disabled pin gives no wake, no interrupt
// - pin level readable in normal and stop
// - pin wake sets pin wake flag
// - bias select: none, pull-down, pull-up
// - bias select three follows detected level
// - interrupt only when pin enabled as source
// - flags sticky until cleared; level never interrupts
// - interrupt output low pulse, no mode change
package wil_pkg;
    localparam int            CLK_MHZ          = 100;
    localparam int            FILTER_TIME_US   = 16;
    localparam int            FILTER_CYC       = FILTER_TIME_US * CLK_MHZ;
    localparam int            INT_PULSE_US     = 100;
    localparam int            INT_GAP_US       = 100;
    localparam int            INT_PULSE_CYC    = INT_PULSE_US * CLK_MHZ;
    localparam int            INT_GAP_CYC      = INT_GAP_US * CLK_MHZ;

    localparam logic [7:0]    CTRL_OFS         = 8'h00;
    localparam logic [7:0]    WAKE_STAT1_OFS   = 8'h04;
    localparam logic [7:0]    LEVEL_STAT_OFS   = 8'h08;
    localparam logic [7:0]    IRQ_STAT_OFS     = 8'h0C;
    localparam logic [7:0]    IRQ_MASK_OFS     = 8'h10;

    localparam int            CTRL_EN_BIT      = 0;
    localparam int            CTRL_CYCLIC_BIT  = 1;
    localparam int            CTRL_MOD_BIT     = 2;
    localparam int            CTRL_BIAS_LO     = 3;
    localparam int            CTRL_BIAS_HI     = 4;
    localparam int            CTRL_W           = 5;
    localparam logic [4:0]    CTRL_RST         = 5'h00;
    localparam logic [1:0]    IRQ_RST          = 2'h0;
    localparam logic [1:0]    MASK_RST         = 2'h0;

    localparam logic [1:0]    BIAS_NONE        = 2'h0;
    localparam logic [1:0]    BIAS_DOWN        = 2'h1;
    localparam logic [1:0]    BIAS_UP          = 2'h2;
    localparam logic [1:0]    BIAS_AUTO        = 2'h3;

    localparam logic [1:0]    MODE_NORMAL      = 2'h0;
    localparam logic [1:0]    MODE_STOP        = 2'h1;
    localparam logic [1:0]    MODE_SLEEP       = 2'h2;
    localparam logic [1:0]    MODE_FAIL_SAFE   = 2'h3;

    localparam logic [1:0]    RESP_OKAY        = 2'h0;
    localparam logic [1:0]    RESP_SLVERR      = 2'h2;

    typedef enum logic [2:0] {
        WIL_PULSE_IDLE = 3'h1,
        WIL_PULSE_LOW  = 3'h2,
        WIL_PULSE_GAP  = 3'h4
    } wil_pulse_state_type;
endpackage

/* File: core/wil_filter.sv */
// pin synchroniser and wake filter
// assumes wake_pin is asynchronous comparator output
`timescale 1ns/1ps
module wil_filter (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic wake_pin,
    output logic      sync_level,
    output logic      filt_level
);
    logic        s1_q;
    logic        s2_q;
    logic        s3_q;
    logic [15:0] cnt_q;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q       <= 1'b0;
            s2_q       <= 1'b0;
            s3_q       <= 1'b0;
            sync_level <= 1'b0;
        end else begin
            s1_q <= wake_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_level <= s3_q;
            end
        end
    end

    // any bounce back clears the count, so short pulses never pass
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q      <= 16'h0000;
            filt_level <= 1'b0;
        end else if (sync_level == filt_level) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q == 16'(wil_pkg::FILTER_CYC - 1)) begin
            cnt_q      <= 16'h0000;
            filt_level <= sync_level;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    a_filter_time: assert property (@(posedge core_clk) disable iff (!rst_b)
        (filt_level != $past(filt_level)) |-> ($past(cnt_q) == 16'(wil_pkg::FILTER_CYC - 1)))
        else $error("filtered level changed before filter time");
endmodule

/* File: core/wil_int_pulse.sv */
// active-low interrupt pulse with minimum high time between pulses
// assumes trigger is a one-cycle pulse on core_clk
`timescale 1ns/1ps
module wil_int_pulse #(
    parameter int PULSE_CYC = wil_pkg::INT_PULSE_CYC,
    parameter int GAP_CYC   = wil_pkg::INT_GAP_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic trigger,
    output logic      int_n
);
    wil_pkg::wil_pulse_state_type state_q;
    logic [15:0]                  cnt_q;
    logic                         pending_q;

    // a trigger during a pulse or gap is held, not dropped
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_q <= 1'b0;
        end else if (trigger) begin
            pending_q <= (state_q != wil_pkg::WIL_PULSE_IDLE);
        end else if (state_q == wil_pkg::WIL_PULSE_IDLE) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= wil_pkg::WIL_PULSE_IDLE;
            cnt_q   <= 16'h0000;
            int_n   <= 1'b1;
        end else begin
            case (state_q)
                wil_pkg::WIL_PULSE_IDLE: begin
                    if (trigger || pending_q) begin
                        state_q <= wil_pkg::WIL_PULSE_LOW;
                        cnt_q   <= 16'h0000;
                        int_n   <= 1'b0;
                    end
                end
                wil_pkg::WIL_PULSE_LOW: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(PULSE_CYC - 1)) begin
                        state_q <= wil_pkg::WIL_PULSE_GAP;
                        cnt_q   <= 16'h0000;
                        int_n   <= 1'b1;
                    end
                end
                wil_pkg::WIL_PULSE_GAP: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(GAP_CYC - 1)) begin
                        state_q <= wil_pkg::WIL_PULSE_IDLE;
                    end
                end
                default: begin
                    state_q <= wil_pkg::WIL_PULSE_IDLE;
                    int_n   <= 1'b1;
                end
            endcase
        end
    end

    a_pulse_low: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(int_n) |=> (!int_n) [*2])
        else $error("interrupt pulse too short");
endmodule

/* File: verification/wil_pin_model.sv */
// model of the switch or signal on the wake pin
// assumes bias enables come from the wake logic; floating pin drifts
`timescale 1ns/1ps
module wil_pin_model (
    input  wire logic drv_en,
    input  wire logic drv_val,
    input  wire logic pull_up_en,
    input  wire logic pull_down_en,
    output logic      wake_pin
);
    logic last_q = 1'h0;
    always @(drv_en or drv_val) begin
        if (drv_en) begin
            last_q = drv_val;
        end
    end
    // open pin without bias must not look stable
    assign wake_pin = drv_en ? drv_val : pull_up_en ? 1'h1 : pull_down_en ? 1'h0 : ~last_q;
endmodule

/* File: verification/wil_top_tb.sv */
// self-checking bench of the wake input logic
// assumes wil_top with shortened interrupt pulse and gap
`timescale 1ns/1ps
module wil_top_tb;
    localparam int         P  = 20;
    localparam logic [7:0] CT = wil_pkg::CTRL_OFS;
    localparam logic [7:0] WS = wil_pkg::WAKE_STAT1_OFS;
    localparam logic [7:0] IS = wil_pkg::IRQ_STAT_OFS;
    logic        core_clk = 1'h0, rst_b = 1'h0, wake_pin, drv_en = 1'h1, drv_val = 1'h0, sense_strobe = 1'h0;
    logic [1:0]  power_mode = wil_pkg::MODE_NORMAL;
    logic        pull_up_en, pull_down_en, mod_override, pwm_select, wake_request, restart_request, int_n, irq;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  ev;
    int          error_cnt = 0, n_compared = 0, cyc = 0;

    wil_top #(.INT_PULSE_CYC(P), .INT_GAP_CYC(P)) u_dut (.*);
    wil_pin_model u_pin (.drv_en(drv_en), .drv_val(drv_val), .pull_up_en(pull_up_en),
                         .pull_down_en(pull_down_en), .wake_pin(wake_pin));
    assign ev = {restart_request, wake_request, ~int_n};
    always #5 core_clk = ~core_clk;

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, about two and a half times the expected run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        fork
            begin
                do @(posedge core_clk); while (s_axi_awready !== 1'h1);
                s_axi_awvalid <= 1'h0;
            end
            begin
                do @(posedge core_clk); while (s_axi_wready !== 1'h1);
                s_axi_wvalid <= 1'h0;
            end
        join
        do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk({30'h0, s_axi_bresp},
            {30'h0, (a <= wil_pkg::IRQ_MASK_OFS && a[1:0] == 2'h0) ? wil_pkg::RESP_OKAY : wil_pkg::RESP_SLVERR});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do @(posedge core_clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    // waits for interrupt low, wake or restart pulse
    task automatic wt(input int k);
        repeat (1700) begin
            @(posedge core_clk);
            if (ev[k] === 1'h1) break;
        end
        chk({31'h0, ev[k]}, 32'h1);
    endtask
    task automatic pin(input logic v);
        @(posedge core_clk);
        drv_val <= v;
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'h1;
        wr(8'h40, 32'h1F);
        rdc(CT, 32'h0, wil_pkg::RESP_OKAY);
        rdc(8'h40, 32'h0, wil_pkg::RESP_SLVERR);
        for (int i = 0; i < 3; i++) begin
            wr(CT, 32'(i) << 3);
            repeat (3) @(posedge core_clk);
            chk({30'h0, pull_up_en, pull_down_en}, 32'(i));
        end
        wr(CT, 32'h1);
        wr(wil_pkg::IRQ_MASK_OFS, 32'h3);
        pin(1'h1);
        repeat (1000) @(posedge core_clk);
        pin(1'h0);
        repeat (1700) @(posedge core_clk);
        rdc(IS, 32'h0, 2'h0);
        pin(1'h1);
        wt(0);
        repeat (19) @(posedge core_clk);
        chk(int_n, 1'h0);
        @(posedge core_clk);
        chk(int_n, 1'h1);
        chk(irq, 1'h1);
        rdc(IS, 32'h1, 2'h0);
        rdc(WS, 32'h1, 2'h0);
        rdc(wil_pkg::LEVEL_STAT_OFS, 32'h1, 2'h0);
        rdc(WS, 32'h1, 2'h0);
        wr(WS, 32'h1);
        wr(IS, 32'h3);
        rdc(WS, 32'h0, 2'h0);
        chk(irq, 1'h0);
        wr(CT, 32'h0);
        pin(1'h0);
        repeat (1700) @(posedge core_clk);
        rdc(IS, 32'h0, 2'h0);
        power_mode <= wil_pkg::MODE_SLEEP;
        wr(CT, 32'h1);
        pin(1'h1);
        wt(1);
        power_mode <= wil_pkg::MODE_FAIL_SAFE;
        wr(CT, 32'h0);
        pin(1'h0);
        wt(2);
        power_mode <= wil_pkg::MODE_STOP;
        wr(CT, 32'h5);
        pin(1'h1);
        repeat (8) @(posedge core_clk);
        chk({mod_override, pwm_select}, 2'h3);
        pin(1'h0);
        repeat (8) @(posedge core_clk);
        chk({mod_override, pwm_select}, 2'h2);
        repeat (1700) @(posedge core_clk);
        wr(WS, 32'h1);
        wr(IS, 32'h3);
        power_mode <= wil_pkg::MODE_NORMAL;
        wr(CT, 32'h3);
        pin(1'h1);
        repeat (1700) @(posedge core_clk);
        rdc(IS, 32'h0, 2'h0);
        sense_strobe <= 1'h1;
        @(posedge core_clk);
        sense_strobe <= 1'h0;
        wt(0);
        wr(CT, 32'h18);
        repeat (3) @(posedge core_clk);
        chk({pull_up_en, pull_down_en}, 2'h2);
        pin(1'h0);
        repeat (1700) @(posedge core_clk);
        chk({pull_up_en, pull_down_en}, 2'h1);
        drv_en <= 1'h0;
        repeat (20) @(posedge core_clk);
        chk(wake_pin, 1'h0);
        end_sim();
    end
endmodule
